/* File: src/fp_pkg.sv */
package fp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned BLINK_HZ = 1;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned FORCE_OFF_MS = 4500;
  localparam int unsigned FORCE_OFF_CYC = CLK_HZ / 1000 * FORCE_OFF_MS;
  localparam int unsigned PULSE_CYC = 16;
  localparam int unsigned CNT_W = 32;
  localparam logic [2:0] ST_RESET = 3'h1;

  // ----------------------------------------------------------------
  // chipset and sequencer power states, faults and status LED
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACPI_S0 = 2'h0,
    ACPI_S1 = 2'h1,
    ACPI_S5 = 2'h3
  } acpi_e;

  typedef enum logic [2:0] {
    PWR_OFF = 3'h1,
    PWR_UP = 3'h2,
    PWR_ON = 3'h4
  } pwr_e;

  typedef struct packed {
    logic fatal;
    logic nonFatal;
    logic degraded;
  } fault_s;

  typedef struct packed {
    logic greenOn;
    logic amberOn;
  } status_led_s;

endpackage : fp_pkg

/* File: src/front_panel_power_led_control.sv */
`timescale 1ns/100ps
// Overview of operation
// - off: button or wake edge starts power-up
// - power-up drives power-good and reset outputs
// - when on, button only requests chipset, never supply
// - chipset off state drops supply on
// - unserviced firmware off request forces off, 4-5 s
// - ACPI OS present: button raises control interrupt
// - reset button forwarded to chipset always
// - identify press toggles ID LED
// - no ACPI: power LED follows DC power
// - ACPI: S5 off, S1 blink, S0 on
// - status LED shows most severe fault
// - amber overrides green status
// - combine external and own fault inputs
// - sensor fault tracks present sensor state
// - status held across power-down on standby
// - healthy solid green, degraded blinking green
// - non-fatal blinking amber, fatal solid amber
module front_panel_power_led_control #(
  // counts overridable so a bench can reach the button paths in a short run
  parameter int unsigned DEBOUNCE_LEN = fp_pkg::DEBOUNCE_CYC,
  parameter int unsigned FORCE_OFF_LEN = fp_pkg::FORCE_OFF_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pwrButton,
  input wire logic rstButton,
  input wire logic idButton,
  input wire logic wakeEvent,
  input wire logic [1:0] acpiState,
  input wire logic acpiEnabled,
  input wire logic osPresent,
  input wire logic idCmdValid,
  input wire logic idCmdOn,
  input wire fp_pkg::fault_s ownFaults,
  input wire fp_pkg::fault_s extFaults,
  output logic supplyOnPin,
  output logic supplyGoodPin,
  output logic platformRstN,
  output logic pwrButtonReq,
  output logic systemControlInterrupt,
  output logic systemManagementInterrupt,
  output logic chipsetRstReq,
  output logic idLed,
  output logic pwrLed,
  output fp_pkg::status_led_s statusLed
);

  typedef struct packed {
    logic [2:0][1:0] sync;
    logic wakeS1;
    logic wakeS2;
    logic wakeD;
    logic [2:0] stable;
    logic [2:0][fp_pkg::CNT_W-1:0] dbCnt;
    fp_pkg::pwr_e pwr;
    logic [fp_pkg::CNT_W-1:0] offCnt;
    logic offPending;
    logic [fp_pkg::CNT_W-1:0] pulseCnt;
    logic [fp_pkg::CNT_W-1:0] blinkCnt;
    logic blink;
    logic supplyOn;
    logic good;
    logic rstN;
    logic btnReq;
    logic system_control_interrupt;
    logic system_management_interrupt;
    logic chipRst;
    logic id;
    logic led;
    fp_pkg::status_led_s status;
  } state_s;

  state_s cur_reg;
  state_s cur_next;
  logic [2:0] press;
  logic wakeEdge;
  fp_pkg::fault_s merged;

  // ----------------------------------------------------------------
  // button debounce
  // ----------------------------------------------------------------
  // press fires once on the debounced rising edge
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_btn
      assign press[gi] = (cur_reg.dbCnt[gi] == fp_pkg::CNT_W'(DEBOUNCE_LEN - 1))
                         && cur_reg.sync[gi][1] && !cur_reg.stable[gi];
    end
  endgenerate

  assign wakeEdge = cur_reg.wakeS2 != cur_reg.wakeD;
  assign merged = ownFaults | extFaults;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.sync[0] = {cur_reg.sync[0][0], pwrButton};
    cur_next.sync[1] = {cur_reg.sync[1][0], rstButton};
    cur_next.sync[2] = {cur_reg.sync[2][0], idButton};
    cur_next.wakeS1 = wakeEvent;
    cur_next.wakeS2 = cur_reg.wakeS1;
    cur_next.wakeD = cur_reg.wakeS2;
    for (int i = 0; i < 3; i++) begin
      if (cur_reg.sync[i][1] == cur_reg.stable[i]) begin
        cur_next.dbCnt[i] = '0;
      end else if (cur_reg.dbCnt[i] == fp_pkg::CNT_W'(DEBOUNCE_LEN - 1)) begin
        cur_next.dbCnt[i] = '0;
        cur_next.stable[i] = cur_reg.sync[i][1];
      end else begin
        cur_next.dbCnt[i] = cur_reg.dbCnt[i] + 1'b1;
      end
    end

    // one-cycle request pulses
    cur_next.btnReq = 1'b0;
    cur_next.system_control_interrupt = 1'b0;
    cur_next.system_management_interrupt = 1'b0;
    cur_next.chipRst = press[1];

    unique case (cur_reg.pwr)
      fp_pkg::PWR_OFF: begin
        cur_next.offPending = 1'b0;
        if (press[0] || wakeEdge) begin
          cur_next.pwr = fp_pkg::PWR_UP;
          cur_next.supplyOn = 1'b1;
          cur_next.pulseCnt = '0;
        end
      end
      fp_pkg::PWR_UP: begin
        cur_next.pulseCnt = cur_reg.pulseCnt + 1'b1;
        if (cur_reg.pulseCnt == fp_pkg::CNT_W'(fp_pkg::PULSE_CYC - 1)) begin
          cur_next.good = 1'b1;
        end
        if (cur_reg.pulseCnt == fp_pkg::CNT_W'(2 * fp_pkg::PULSE_CYC - 1)) begin
          cur_next.rstN = 1'b1;
          cur_next.pwr = fp_pkg::PWR_ON;
        end
      end
      fp_pkg::PWR_ON: begin
        if (press[0]) begin
          // request only; supply stays up until chipset or timeout
          cur_next.btnReq = 1'b1;
          cur_next.system_control_interrupt = osPresent;
          cur_next.system_management_interrupt = !osPresent;
          // an os press must not leave a stale timer for a later firmware press
          if (!osPresent && !cur_reg.offPending) begin
            cur_next.offPending = 1'b1;
            cur_next.offCnt = '0;
          end
        end else if (cur_reg.offPending) begin
          cur_next.offCnt = cur_reg.offCnt + 1'b1;
        end
        // the os may choose to stay on; only the firmware path times out
        if ((acpiState == fp_pkg::ACPI_S5) || (cur_reg.offPending && !osPresent
            && cur_reg.offCnt == fp_pkg::CNT_W'(FORCE_OFF_LEN - 1))) begin
          cur_next.pwr = fp_pkg::PWR_OFF;
          cur_next.supplyOn = 1'b0;
          cur_next.good = 1'b0;
          cur_next.rstN = 1'b0;
          cur_next.offPending = 1'b0;
        end
      end
    endcase

    // identify: latest source wins
    if (press[2]) begin
      cur_next.id = !cur_reg.id;
    end else if (idCmdValid) begin
      cur_next.id = idCmdOn;
    end

    if (cur_reg.blinkCnt == fp_pkg::CNT_W'(fp_pkg::BLINK_HALF_CYC - 1)) begin
      cur_next.blinkCnt = '0;
      cur_next.blink = !cur_reg.blink;
    end else begin
      cur_next.blinkCnt = cur_reg.blinkCnt + 1'b1;
    end

    if (!acpiEnabled) begin
      cur_next.led = cur_reg.good;
    end else begin
      unique case (acpiState)
        fp_pkg::ACPI_S0: cur_next.led = 1'b1;
        fp_pkg::ACPI_S1: cur_next.led = cur_reg.blink;
        default: cur_next.led = 1'b0;
      endcase
    end

    // status runs regardless of power state, on standby
    cur_next.status.amberOn = 1'b0;
    cur_next.status.greenOn = 1'b0;
    if (merged.fatal) begin
      cur_next.status.amberOn = 1'b1;
    end else if (merged.nonFatal) begin
      cur_next.status.amberOn = cur_reg.blink;
    end else if (merged.degraded) begin
      cur_next.status.greenOn = cur_reg.blink;
    end else begin
      cur_next.status.greenOn = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_reg <= '0;
      cur_reg.pwr <= fp_pkg::PWR_OFF;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign supplyOnPin = cur_reg.supplyOn;
  assign supplyGoodPin = cur_reg.good;
  assign platformRstN = cur_reg.rstN;
  assign pwrButtonReq = cur_reg.btnReq;
  assign systemControlInterrupt = cur_reg.system_control_interrupt;
  assign systemManagementInterrupt = cur_reg.system_management_interrupt;
  assign chipsetRstReq = cur_reg.chipRst;
  assign idLed = cur_reg.id;
  assign pwrLed = cur_reg.led;
  assign statusLed = cur_reg.status;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_off_start;
    @(posedge clock) disable iff (!nrst)
      (cur_reg.pwr == fp_pkg::PWR_OFF && wakeEdge) |=> supplyOnPin;
  endproperty
  a_off_start: assert property (p_off_start) else $error("no power-up on wake");

  property p_good_before_rst;
    @(posedge clock) disable iff (!nrst)
      $rose(platformRstN) |-> supplyGoodPin;
  endproperty
  a_good_before_rst: assert property (p_good_before_rst) else $error("reset before good");

  property p_btn_no_supply;
    @(posedge clock) disable iff (!nrst)
      (cur_reg.pwr == fp_pkg::PWR_ON && press[0] && acpiState != fp_pkg::ACPI_S5
       && !(cur_reg.offPending && cur_reg.offCnt ==
            fp_pkg::CNT_W'(FORCE_OFF_LEN - 1))) |=> supplyOnPin && pwrButtonReq;
  endproperty
  a_btn_no_supply: assert property (p_btn_no_supply) else $error("button cut supply");

  property p_s5_off;
    @(posedge clock) disable iff (!nrst)
      (cur_reg.pwr == fp_pkg::PWR_ON && acpiState == fp_pkg::ACPI_S5) |=> !supplyOnPin;
  endproperty
  a_s5_off: assert property (p_s5_off) else $error("supply on in S5");

  property p_sci;
    @(posedge clock) disable iff (!nrst)
      (cur_reg.pwr == fp_pkg::PWR_ON && press[0] && osPresent) |=> systemControlInterrupt;
  endproperty
  a_sci: assert property (p_sci) else $error("no control interrupt");

  property p_rst_fwd;
    @(posedge clock) disable iff (!nrst)
      press[1] |=> chipsetRstReq;
  endproperty
  a_rst_fwd: assert property (p_rst_fwd) else $error("reset not forwarded");

  property p_id_toggle;
    @(posedge clock) disable iff (!nrst)
      press[2] |=> idLed != $past(idLed);
  endproperty
  a_id_toggle: assert property (p_id_toggle) else $error("ID LED not toggled");

  property p_fatal;
    @(posedge clock) disable iff (!nrst)
      merged.fatal |=> statusLed.amberOn && !statusLed.greenOn;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not solid amber");

  property p_force_off;
    @(posedge clock) disable iff (!nrst)
      (cur_reg.pwr == fp_pkg::PWR_ON && cur_reg.offPending && !osPresent
       && cur_reg.offCnt == fp_pkg::CNT_W'(FORCE_OFF_LEN - 1)) |=> !supplyOnPin;
  endproperty
  a_force_off: assert property (p_force_off) else $error("no forced power-off");

  property p_led_s0;
    @(posedge clock) disable iff (!nrst)
      (acpiEnabled && acpiState == fp_pkg::ACPI_S0) |=> pwrLed;
  endproperty
  a_led_s0: assert property (p_led_s0) else $error("power LED dark in S0");

  property p_healthy;
    @(posedge clock) disable iff (!nrst)
      (merged == 3'h0) |=> statusLed.greenOn && !statusLed.amberOn;
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy not solid green");

  property p_id_cmd;
    @(posedge clock) disable iff (!nrst)
      (idCmdValid && !press[2]) |=> idLed == $past(idCmdOn);
  endproperty
  a_id_cmd: assert property (p_id_cmd) else $error("ID command ignored");

endmodule : front_panel_power_led_control

/* File: testbench/chipset_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// chipset power logic stand-in
// ----------------------------------------
module chipset_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic supplyGood,
  input wire logic pwrReq,
  input wire logic osPresent,
  input wire logic fwServices,
  input wire logic wakeReq,
  input wire logic [1:0] sleepCmd,
  output logic [1:0] acpiState,
  output logic wakeEvent
);
  logic offReq_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      offReq_reg <= 1'h0;
      wakeEvent <= 1'h0;
    end else begin
      // silent firmware leaves the request pending for the safety timer
      if (pwrReq && !osPresent && fwServices) begin
        offReq_reg <= 1'h1;
      end else if (!supplyGood) begin
        offReq_reg <= 1'h0;
      end
      if (wakeReq) begin
        wakeEvent <= ~wakeEvent;
      end
    end
  end
  // no power-good means the chipset sits in soft-off
  assign acpiState = (!supplyGood || offReq_reg) ? 2'h3 : sleepCmd;
endmodule : chipset_model

/* File: testbench/test_front_panel_power_led_control.sv */
`timescale 1ns/100ps
module test_front_panel_power_led_control;
  logic clock, nrst, wakeReq, osPresent, acpiEnabled, idCmdValid, idCmdOn;
  logic [1:0] sleepCmd, acpiState;
  logic wakeEvent, supOn, supGood, platRstN, pwrReq, idLed, pwrLed;
  logic system_control_interrupt, system_management_interrupt, chipRstReq, fwServices;
  logic [2:0] btn;
  fp_pkg::fault_s ownFaults, extFaults;
  fp_pkg::status_led_s statusLed;
  int n_fail, n_tests;
  int reqCnt, sciCnt, smiCnt, rstCnt;
  localparam int unsigned DEBOUNCE_LEN = 4;
  localparam int unsigned FORCE_OFF_LEN = 200;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  // short counts so the button paths fit in one run
  front_panel_power_led_control #(.DEBOUNCE_LEN(DEBOUNCE_LEN), .FORCE_OFF_LEN(FORCE_OFF_LEN))
    dut (.clock(clock), .nrst(nrst), .pwrButton(btn[0]),
    .rstButton(btn[1]), .idButton(btn[2]), .wakeEvent(wakeEvent), .acpiState(acpiState),
    .acpiEnabled(acpiEnabled), .osPresent(osPresent), .idCmdValid(idCmdValid),
    .idCmdOn(idCmdOn), .ownFaults(ownFaults), .extFaults(extFaults), .supplyOnPin(supOn),
    .supplyGoodPin(supGood), .platformRstN(platRstN), .pwrButtonReq(pwrReq),
    .systemControlInterrupt(system_control_interrupt), .systemManagementInterrupt(system_management_interrupt), .chipsetRstReq(chipRstReq),
    .idLed(idLed), .pwrLed(pwrLed), .statusLed(statusLed));
  chipset_model partner (.clock(clock), .nrst(nrst), .supplyGood(supGood), .pwrReq(pwrReq),
    .osPresent(osPresent), .fwServices(fwServices), .wakeReq(wakeReq), .sleepCmd(sleepCmd),
    .acpiState(acpiState), .wakeEvent(wakeEvent));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // pulse counters: one press must give exactly one pulse
  always @(posedge clock) begin
    if (pwrReq === 1'h1) reqCnt++;
    if (system_control_interrupt === 1'h1) sciCnt++;
    if (system_management_interrupt === 1'h1) smiCnt++;
    if (chipRstReq === 1'h1) rstCnt++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic clear_counts;
    reqCnt = 0;
    sciCnt = 0;
    smiCnt = 0;
    rstCnt = 0;
  endtask : clear_counts
  // press lands 2 + DEBOUNCE_LEN edges in; release settles before return
  task automatic press_button(input int which);
    btn[which] = 1'h1;
    tick(10);
    btn[which] = 1'h0;
    tick(10);
  endtask : press_button
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic wake_power_up;
    int i;
    wakeReq = 1'h1;
    tick(1);
    wakeReq = 1'h0;
    for (i = 0; i < 20 && supOn !== 1'h1; i++) tick(1);
    check("supply on", 7'h1, {6'h0, supOn});
    if (supOn !== 1'h1) tally_and_finish();
    tick(15);
    check("good early", 7'h0, {6'h0, supGood});
    tick(1);
    check("good", 7'h1, {6'h0, supGood});
    tick(15);
    check("rst early", 7'h0, {6'h0, platRstN});
    tick(1);
    check("rst released", 7'h1, {6'h0, platRstN});
    check("button request", 7'h0, 7'(reqCnt));
  endtask : wake_power_up
  task automatic power_led_on;
    tick(2);
    check("led no acpi", 7'h1, {6'h0, pwrLed});
    acpiEnabled = 1'h1;
    tick(2);
    check("led s0", 7'h1, {6'h0, pwrLed});
    // blink opens dark and its half period outlasts the whole run
    sleepCmd = 2'h1;
    tick(2);
    check("led s1", 7'h0, {6'h0, pwrLed});
    sleepCmd = 2'h0;
    tick(2);
    check("led back to s0", 7'h1, {6'h0, pwrLed});
  endtask : power_led_on
  task automatic status_table;
    int i;
    logic [2:0] f;
    for (i = 0; i < 17; i++) begin
      f = 3'(i % 8);
      ownFaults = (i < 8) ? f : 3'h0;
      extFaults = (i < 8) ? 3'h0 : f;
      tick(2);
      // blinking colour phase is unknown, only the dark colour is judged
      if (f[2]) check("fatal", 7'h1, {5'h0, statusLed});
      else if (f[1]) check("nonfatal", 7'h0, {6'h0, statusLed.greenOn});
      else if (f[0]) check("degraded", 7'h0, {6'h0, statusLed.amberOn});
      else check("healthy", 7'h2, {5'h0, statusLed});
    end
    ownFaults = 3'h2;
    extFaults = 3'h4;
    tick(2);
    check("most severe", 7'h1, {5'h0, statusLed});
  endtask : status_table
  task automatic chipset_off;
    sleepCmd = 2'h3;
    tick(3);
    check("supply off", 7'h0, {4'h0, supOn, supGood, platRstN});
    tick(2);
    check("led s5", 7'h0, {6'h0, pwrLed});
    check("status held", 7'h1, {5'h0, statusLed});
  endtask : chipset_off
  task automatic identify_cmd;
    idCmdValid = 1'h1;
    idCmdOn = 1'h1;
    tick(1);
    idCmdValid = 1'h0;
    tick(20);
    check("id lit", 7'h1, {6'h0, idLed});
    idCmdValid = 1'h1;
    idCmdOn = 1'h0;
    tick(1);
    idCmdValid = 1'h0;
    tick(2);
    check("id dark", 7'h0, {6'h0, idLed});
  endtask : identify_cmd
  task automatic correctable_errors;
    int n;
    ownFaults = 3'h0;
    extFaults = 3'h0;
    // firmware stand-in: nine errors stay silent, the tenth reports non-fatal
    for (n = 1; n <= 10; n++) begin
      if (n == 10) extFaults = 3'h2;
      tick(2);
      if (n == 9) check("nine errors", 7'h2, {5'h0, statusLed});
    end
    check("ten errors", 7'h0, {6'h0, statusLed.greenOn});
  endtask : correctable_errors
  task automatic power_button_cycle;
    sleepCmd = 2'h0;
    clear_counts();
    press_button(0);
    check("button power-up", 7'h1, {6'h0, supOn});
    check("no request when off", 7'h0, 7'(reqCnt));
    tick(20);
    check("button reset release", 7'h1, {6'h0, platRstN});
    osPresent = 1'h1;
    press_button(0);
    check("os request", 7'h1, 7'(reqCnt));
    check("control interrupt", 7'h1, 7'(sciCnt));
    check("no management interrupt", 7'h0, 7'(smiCnt));
    tick(FORCE_OFF_LEN + 20);
    check("os keeps power", 7'h1, {6'h0, supOn});
    osPresent = 1'h0;
    fwServices = 1'h0;
    clear_counts();
    press_button(0);
    check("management interrupt", 7'h1, 7'(smiCnt));
    // press at edge 6, forced off FORCE_OFF_LEN edges later; 20 edges used
    tick(FORCE_OFF_LEN - 16);
    check("forced off early", 7'h1, {6'h0, supOn});
    tick(2);
    check("forced off", 7'h0, {6'h0, supOn});
    fwServices = 1'h1;
    press_button(0);
    tick(20);
    clear_counts();
    press_button(0);
    check("firmware shutdown", 7'h0, {6'h0, supOn});
    check("one request per press", 7'h1, 7'(reqCnt));
  endtask : power_button_cycle
  task automatic reset_and_id_buttons;
    clear_counts();
    press_button(1);
    check("reset forwarded", 7'h1, 7'(rstCnt));
    press_button(2);
    check("id button on", 7'h1, {6'h0, idLed});
    press_button(2);
    check("id button off", 7'h0, {6'h0, idLed});
  endtask : reset_and_id_buttons
  initial begin
    {nrst, wakeReq, osPresent, acpiEnabled, idCmdValid, idCmdOn} = 6'h0;
    btn = 3'h0;
    fwServices = 1'h1;
    sleepCmd = 2'h0;
    ownFaults = 3'h0;
    extFaults = 3'h0;
    n_fail = 0;
    n_tests = 0;
    clear_counts();
    repeat (12) @(posedge clock);
    #1;
    check("reset outputs", 7'h0, {supOn, supGood, platRstN, idLed, pwrLed, statusLed});
    nrst = 1'h1;
    tick(2);
    wake_power_up();
    power_led_on();
    status_table();
    chipset_off();
    correctable_errors();
    identify_cmd();
    power_button_cycle();
    reset_and_id_buttons();
    tally_and_finish();
  end
endmodule : test_front_panel_power_led_control
